//--- common/sbst_if.sv
// controller state and decoded phases shared inside the test port
`timescale 1ns/1ns
interface sbst_if;
    logic tms;
    logic en;
    sbst_pkg::sbst_state_type state;
    logic in_reset;
    logic cap_dr;
    logic sh_dr;
    logic up_dr;
    logic cap_ir;
    logic sh_ir;
    logic up_ir;

    modport fsm (
        input tms, en,
        output state, in_reset, cap_dr, sh_dr, up_dr, cap_ir, sh_ir, up_ir
    );
    modport user (
        output tms, en,
        input state, in_reset, cap_dr, sh_dr, up_dr, cap_ir, sh_ir, up_ir
    );
endinterface

//--- common/sbst_pkg.sv
// shared constants and types of the memory boundary-scan test port
package sbst_pkg;

    // ----------------------------------------------------------------
    // register widths
    // ----------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W_DEF = 8;

    // ----------------------------------------------------------------
    // instruction codes and capture pattern
    // ----------------------------------------------------------------
    localparam logic [2:0] OP_EXTEST = 3'h0;
    localparam logic [2:0] OP_IDCODE = 3'h1;
    localparam logic [2:0] OP_SAMPLE = 3'h2;
    localparam logic [2:0] OP_SAMPLE_Z = 3'h4;
    localparam logic [2:0] OP_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // identification code: value is arbitrary, bit 0 kept high
    localparam logic [31:0] ID_CODE_DEF = 32'h0000_0001;

    // ----------------------------------------------------------------
    // controller states, gray coded along the usual path
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h3,
        ST_CAP_DR = 4'h2,
        ST_SH_DR = 4'h6,
        ST_EX1_DR = 4'h7,
        ST_PAU_DR = 4'h5,
        ST_EX2_DR = 4'h4,
        ST_UP_DR = 4'hC,
        ST_SEL_IR = 4'hD,
        ST_CAP_IR = 4'hF,
        ST_SH_IR = 4'hE,
        ST_EX1_IR = 4'hA,
        ST_PAU_IR = 4'hB,
        ST_EX2_IR = 4'h9,
        ST_UP_IR = 4'h8
    } sbst_state_type;

endpackage

//--- src/sbst_tap.sv
// boundary-scan test access port of the synchronous memory
`timescale 1ns/1ns
// Overview of operation
// R01: sample inputs rising, change outputs falling
// R02: undriven mode-select acts as logic one
// R03: undriven data input shifts in ones
// R04: state and instruction select serial register
// R05: data output driven only while shifting
// R06: five high mode-select edges force reset
// R07: power-up reset, inactive until clock toggles
// R08: unused port leaves memory undisturbed
// R09: behave per 1990 boundary-scan standard
// R10: three-bit instruction, identification after reset
// R11: capture-instruction loads 01 into low bits
// R12: bypass is one flip-flop stage
// R13: 32-bit identification, lsb shifted first
// R14: sixteen-state graph advanced by mode-select
module sbst_tap #(
    parameter int BSR_W = sbst_pkg::BSR_W_DEF,
    parameter logic [31:0] ID_CODE = sbst_pkg::ID_CODE_DEF
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic I_CLK_EN,
    input wire logic I_TCK,
    input wire logic I_TMS,
    input wire logic I_TMS_EN,
    input wire logic I_TDI,
    input wire logic I_TDI_EN,
    input wire logic [BSR_W-1:0] I_PINS,
    output logic O_TDO,
    output logic O_TDO_OE,
    output logic [BSR_W-1:0] O_BSR_DRIVE,
    output logic O_EXTEST_MODE,
    output logic O_HIZ_MODE
);

    // ----------------------------------------------------------------
    // reset and enable for the test clock domain
    // ----------------------------------------------------------------
    logic trst_meta_r;
    logic trst_n_r;
    logic ten_meta_r;
    logic ten_r;

    always_ff @(posedge I_TCK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            trst_meta_r <= 1'b0;
            trst_n_r <= 1'b0;
            ten_meta_r <= 1'b0;
            ten_r <= 1'b0;
        end
        else
        begin
            trst_meta_r <= 1'b1;
            trst_n_r <= trst_meta_r;
            ten_meta_r <= I_CLK_EN;
            ten_r <= ten_meta_r;
        end
    end

    sbst_if tap ();

    // pad pull-ups: an undriven pin reads as one
    assign tap.tms = I_TMS_EN ? I_TMS : 1'b1; // [R02]
    assign tap.en = ten_r;

    sbst_tap_fsm u_fsm (
        .i_tck(I_TCK),
        .i_rst_n(trst_n_r),
        .bus(tap.fsm)
    );

    wire tdi_eff = I_TDI_EN ? I_TDI : 1'b1; // [R03]

    // ----------------------------------------------------------------
    // instruction register
    // ----------------------------------------------------------------
    logic [sbst_pkg::IR_W-1:0] ir_sh_r;
    logic [sbst_pkg::IR_W-1:0] ir_r;
    // mode bits registered with the instruction, glitch-free for the crossing
    logic [1:0] mode_tck_r;

    // test-mode bits an instruction drives into the memory core
    function automatic logic [1:0] mode_of(
        input logic [sbst_pkg::IR_W-1:0] op);
        return {op == sbst_pkg::OP_SAMPLE_Z, op == sbst_pkg::OP_EXTEST};
    endfunction

    always_ff @(posedge I_TCK or negedge trst_n_r)
    begin
        if (!trst_n_r)
            ir_sh_r <= sbst_pkg::OP_IDCODE;
        else if (ten_r && tap.cap_ir)
            ir_sh_r <= sbst_pkg::IR_CAPTURE; // [R11]
        else if (ten_r && tap.sh_ir)
            ir_sh_r <= {tdi_eff, ir_sh_r[sbst_pkg::IR_W-1:1]}; // [R09]
    end

    // update on the falling edge of the update state
    always_ff @(negedge I_TCK or negedge trst_n_r)
    begin
        if (!trst_n_r)
        begin
            ir_r <= sbst_pkg::OP_IDCODE; // [R10]
            mode_tck_r <= 2'h0;
        end
        else if (ten_r && tap.in_reset)
        begin
            ir_r <= sbst_pkg::OP_IDCODE; // [R10]
            mode_tck_r <= 2'h0;
        end
        else if (ten_r && tap.up_ir)
        begin
            ir_r <= ir_sh_r; // [R09]
            mode_tck_r <= mode_of(ir_sh_r); // [R08]
        end
    end

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    wire sel_id = (ir_r == sbst_pkg::OP_IDCODE);
    wire sel_extest = (ir_r == sbst_pkg::OP_EXTEST);
    wire sel_hiz = (ir_r == sbst_pkg::OP_SAMPLE_Z);
    wire sel_bsr = sel_extest || sel_hiz || (ir_r == sbst_pkg::OP_SAMPLE);
    wire sel_byp = !sel_id && !sel_bsr;

    // ----------------------------------------------------------------
    // data registers
    // ----------------------------------------------------------------
    logic byp_r;
    logic [sbst_pkg::ID_W-1:0] id_r;
    logic [BSR_W-1:0] bsr_r;
    logic [BSR_W-1:0] pin_meta_r;
    logic [BSR_W-1:0] pin_r;
    logic [BSR_W-1:0] bsr_upd_r;

    // memory pins run on their own clock
    always_ff @(posedge I_TCK or negedge trst_n_r)
    begin
        if (!trst_n_r)
        begin
            pin_meta_r <= '0;
            pin_r <= '0;
        end
        else if (ten_r)
        begin
            pin_meta_r <= I_PINS;
            pin_r <= pin_meta_r;
        end
    end

    always_ff @(posedge I_TCK or negedge trst_n_r)
    begin
        if (!trst_n_r)
        begin
            byp_r <= 1'b0;
            id_r <= '0;
            bsr_r <= '0;
        end
        else if (ten_r && tap.cap_dr)
        begin
            byp_r <= 1'b0; // [R12]
            if (sel_id)
                id_r <= ID_CODE; // [R13]
            if (sel_bsr)
                bsr_r <= pin_r;
        end
        else if (ten_r && tap.sh_dr)
        begin
            if (sel_byp)
                byp_r <= tdi_eff; // [R12]
            if (sel_id)
                id_r <= {tdi_eff, id_r[sbst_pkg::ID_W-1:1]}; // [R13]
            if (sel_bsr)
                bsr_r <= {tdi_eff, bsr_r[BSR_W-1:1]};
        end
    end

    always_ff @(negedge I_TCK or negedge trst_n_r)
    begin
        if (!trst_n_r)
            bsr_upd_r <= '0;
        else if (ten_r && tap.up_dr && sel_bsr)
            bsr_upd_r <= bsr_r;
    end

    // ----------------------------------------------------------------
    // serial output on the falling edge
    // ----------------------------------------------------------------
    wire dr_bit = sel_id ? id_r[0] : (sel_bsr ? bsr_r[0] : byp_r);
    wire tdo_nxt = tap.sh_ir ? ir_sh_r[0] : dr_bit; // [R04]
    wire tdo_oe_nxt = tap.sh_ir || tap.sh_dr; // [R05]

    always_ff @(negedge I_TCK or negedge trst_n_r)
    begin
        if (!trst_n_r)
        begin
            O_TDO <= 1'b0;
            O_TDO_OE <= 1'b0; // [R07]
        end
        else if (ten_r)
        begin
            O_TDO <= tdo_nxt; // [R01] [R04]
            O_TDO_OE <= tdo_oe_nxt; // [R05]
        end
    end

    assign O_BSR_DRIVE = bsr_upd_r;

    // ----------------------------------------------------------------
    // memory-clock side: test modes reach the core as synced levels
    // ----------------------------------------------------------------
    logic rrst_meta_r;
    logic rrst_n_r;
    logic [1:0] mode_meta_r;
    logic [1:0] mode_r;

    always_ff @(posedge I_REF_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            rrst_meta_r <= 1'b0;
            rrst_n_r <= 1'b0;
        end
        else
        begin
            rrst_meta_r <= 1'b1;
            rrst_n_r <= rrst_meta_r;
        end
    end

    // only extest or high-z instructions touch the memory outputs
    always_ff @(posedge I_REF_CLK or negedge rrst_n_r)
    begin
        if (!rrst_n_r)
        begin
            mode_meta_r <= 2'h0;
            mode_r <= 2'h0;
            O_EXTEST_MODE <= 1'b0;
            O_HIZ_MODE <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            mode_meta_r <= mode_tck_r;
            mode_r <= mode_meta_r;
            O_EXTEST_MODE <= mode_r[0]; // [R08]
            O_HIZ_MODE <= mode_r[1]; // [R08]
        end
    end

endmodule

//--- src/sbst_tap_fsm.sv
// sixteen-state test port controller
`timescale 1ns/1ns
module sbst_tap_fsm (
    input wire logic i_tck,
    input wire logic i_rst_n,
    sbst_if.fsm bus
);

    sbst_pkg::sbst_state_type state_r;
    sbst_pkg::sbst_state_type state_nxt;

    // ----------------------------------------------------------------
    // transition graph
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            sbst_pkg::ST_RESET:
                state_nxt = bus.tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_IDLE:
                state_nxt = bus.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_DR:
                state_nxt = bus.tms ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
            sbst_pkg::ST_CAP_DR:
                state_nxt = bus.tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_SH_DR:
                state_nxt = bus.tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_EX1_DR:
                state_nxt = bus.tms ? sbst_pkg::ST_UP_DR : sbst_pkg::ST_PAU_DR;
            sbst_pkg::ST_PAU_DR:
                state_nxt = bus.tms ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PAU_DR;
            sbst_pkg::ST_EX2_DR:
                state_nxt = bus.tms ? sbst_pkg::ST_UP_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_UP_DR:
                state_nxt = bus.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            sbst_pkg::ST_SEL_IR:
                state_nxt = bus.tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_CAP_IR;
            sbst_pkg::ST_CAP_IR:
                state_nxt = bus.tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_SH_IR:
                state_nxt = bus.tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_EX1_IR:
                state_nxt = bus.tms ? sbst_pkg::ST_UP_IR : sbst_pkg::ST_PAU_IR;
            sbst_pkg::ST_PAU_IR:
                state_nxt = bus.tms ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PAU_IR;
            sbst_pkg::ST_EX2_IR:
                state_nxt = bus.tms ? sbst_pkg::ST_UP_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_UP_IR:
                state_nxt = bus.tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            default:
                state_nxt = sbst_pkg::ST_RESET;
        endcase
    end

    // five high mode-select edges reach reset from any state
    always_ff @(posedge i_tck or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_r <= sbst_pkg::ST_RESET; // [R07]
        else if (bus.en)
            state_r <= state_nxt; // [R14] [R06] [R01]
    end

    assign bus.state = state_r;
    assign bus.in_reset = (state_r == sbst_pkg::ST_RESET);
    assign bus.cap_dr = (state_r == sbst_pkg::ST_CAP_DR);
    assign bus.sh_dr = (state_r == sbst_pkg::ST_SH_DR);
    assign bus.up_dr = (state_r == sbst_pkg::ST_UP_DR);
    assign bus.cap_ir = (state_r == sbst_pkg::ST_CAP_IR);
    assign bus.sh_ir = (state_r == sbst_pkg::ST_SH_IR);
    assign bus.up_ir = (state_r == sbst_pkg::ST_UP_IR);

endmodule

//--- testbench/sbst_jtag_host.sv
// scan controller model driving the test link
`timescale 1ns/1ns
module sbst_jtag_host (
    input wire logic i_tdo,
    output logic o_tck,
    output logic o_tms,
    output logic o_tms_en,
    output logic o_tdi,
    output logic o_tdi_en
);
    initial
    begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tms_en = 1'b1;
        o_tdi = 1'b0;
        o_tdi_en = 1'b1;
    end

    // one clock period; the clock stands low between calls
    task automatic tick(input logic tm, input logic tme, input logic di,
        input logic die, output logic q);
        o_tms_en = tme;
        o_tms = tme ? tm : ~o_tms;
        o_tdi_en = die;
        o_tdi = die ? di : ~o_tdi;
        #2;
        q = i_tdo;
        o_tck = 1'b1;
        #3 o_tck = 1'b0;
        #1;
    endtask

    task automatic go_reset(input logic tme);
        logic q;
        repeat (5) tick(1'b1, tme, 1'b0, 1'b1, q);
        tick(1'b0, 1'b1, 1'b0, 1'b1, q);
    endtask

    // from idle: capture, shift n bits lsb first, update, back to idle
    task automatic scan(input logic is_ir, input int n,
        input logic [63:0] din, input logic die, input logic [63:0] mask,
        output logic [63:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b1, 1'b0, 1'b1, q);
        if (is_ir)
            tick(1'b1, 1'b1, 1'b0, 1'b1, q);
        tick(1'b0, 1'b1, 1'b0, 1'b1, q);
        tick(1'b0, 1'b1, 1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, 1'b1, din[i], die, q);
            dout[i] = q & mask[i];
        end
        tick(1'b1, 1'b1, 1'b0, 1'b1, q);
        tick(1'b0, 1'b1, 1'b0, 1'b1, q);
    endtask
endmodule

//--- testbench/sbst_tap_props.sv
// pin-level assertions of the memory test port
`timescale 1ns/1ns
module sbst_tap_props #(
    parameter int BSR_W = 8,
    parameter logic [31:0] ID_CODE = 32'h1
) (
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    input wire logic I_CLK_EN,
    input wire logic I_TCK,
    input wire logic I_TMS,
    input wire logic I_TMS_EN,
    input wire logic O_TDO,
    input wire logic O_TDO_OE,
    input wire logic [BSR_W-1:0] O_BSR_DRIVE,
    input wire logic O_EXTEST_MODE,
    input wire logic O_HIZ_MODE
);
    logic [1:0] en_r;
    logic tdo_rise_r;
    logic oe_rise_r;
    wire logic tms_v = I_TMS | ~I_TMS_EN;
    wire logic live = I_CLK_EN & (&en_r);
    wire logic hi = live & tms_v;
    wire logic lo = live & ~tms_v;

    // enable must have been high long enough to pass its synchroniser
    always_ff @(posedge I_TCK or negedge I_RST_N)
        if (!I_RST_N)
            en_r <= 2'h0;
        else
            en_r <= {en_r[0], I_CLK_EN};

    // data out as it stood just before the last rising edge
    always_ff @(posedge I_TCK or negedge I_RST_N)
        if (!I_RST_N)
        begin
            tdo_rise_r <= 1'b0;
            oe_rise_r <= 1'b0;
        end
        else
        begin
            tdo_rise_r <= O_TDO;
            oe_rise_r <= O_TDO_OE;
        end

    sequence s_reset;
        hi [*5];
    endsequence
    sequence s_to_dr;
        lo ##1 hi ##1 lo ##1 lo;
    endsequence
    sequence s_to_ir;
        lo ##1 hi ##1 hi ##1 lo ##1 lo;
    endsequence

    a_tdo_fall_only: assert property (
        @(negedge I_TCK) disable iff (!I_RST_N)
        O_TDO == tdo_rise_r && O_TDO_OE == oe_rise_r)
        else $error("data out moved on a rising edge");
    a_tms_hi_exit: assert property (
        @(posedge I_TCK) disable iff (!I_RST_N) hi |=> !O_TDO_OE)
        else $error("data out driven outside shift");
    a_shift_holds: assert property (
        @(posedge I_TCK) disable iff (!I_RST_N)
        lo && O_TDO_OE |=> O_TDO_OE)
        else $error("shift left with mode-select low");
    a_reset_id_lsb: assert property (
        @(posedge I_TCK) disable iff (!I_RST_N)
        s_reset ##1 s_to_dr |=> O_TDO_OE && O_TDO == ID_CODE[0])
        else $error("first id bit wrong after reset");
    a_ir_cap_one: assert property (
        @(posedge I_TCK) disable iff (!I_RST_N)
        s_reset ##1 s_to_ir |=> O_TDO_OE && O_TDO)
        else $error("instruction capture bit 0 wrong");
    a_ir_cap_zero: assert property (
        @(posedge I_TCK) disable iff (!I_RST_N)
        s_reset ##1 s_to_ir ##1 lo |=> O_TDO_OE && !O_TDO)
        else $error("instruction capture bit 1 wrong");
    a_mode_reset: assert property (
        @(posedge I_TCK) disable iff (!I_RST_N)
        s_reset |-> ##6 !O_EXTEST_MODE && !O_HIZ_MODE)
        else $error("test mode kept after controller reset");
    a_frozen_hold: assert property (
        @(posedge I_TCK) disable iff (!I_RST_N) (!I_CLK_EN) [*5] |->
        $stable(O_TDO) && $stable(O_TDO_OE) && $stable(O_BSR_DRIVE))
        else $error("outputs moved while disabled");
endmodule

bind sbst_tap sbst_tap_props #(.BSR_W(BSR_W), .ID_CODE(ID_CODE)) u_props (
    .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CLK_EN(I_CLK_EN),
    .I_TCK(I_TCK), .I_TMS(I_TMS), .I_TMS_EN(I_TMS_EN), .O_TDO(O_TDO),
    .O_TDO_OE(O_TDO_OE), .O_BSR_DRIVE(O_BSR_DRIVE),
    .O_EXTEST_MODE(O_EXTEST_MODE), .O_HIZ_MODE(O_HIZ_MODE)
);

//--- testbench/sbst_tap_tb_top.sv
// self-checking bench of the memory test port
`timescale 1ns/1ns
module sbst_tap_tb_top;
    localparam int BW = sbst_pkg::BSR_W_DEF;
    // identification value is arbitrary
    localparam logic [31:0] ID_VAL = 32'h5A3C_96E1;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [BW-1:0] pins = '0;
    logic [BW-1:0] drive;
    logic tck, tms, tms_en, tdi, tdi_en, tdo, tdo_oe, extest, hiz;
    int miscompares = 0;
    int compares = 0;
    int seed = 32'h3E14;

    sbst_tap #(.BSR_W(BW), .ID_CODE(ID_VAL)) u_dut (
        .I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_CLK_EN(clk_en),
        .I_TCK(tck), .I_TMS(tms), .I_TMS_EN(tms_en), .I_TDI(tdi),
        .I_TDI_EN(tdi_en), .I_PINS(pins), .O_TDO(tdo), .O_TDO_OE(tdo_oe),
        .O_BSR_DRIVE(drive), .O_EXTEST_MODE(extest), .O_HIZ_MODE(hiz)
    );
    sbst_jtag_host u_host (
        .i_tdo(tdo),
        .o_tck(tck), .o_tms(tms), .o_tms_en(tms_en), .o_tdi(tdi),
        .o_tdi_en(tdi_en)
    );

    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic cmp_vec(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // serial stream seen at data out for each instruction
    function automatic logic [63:0] exp_dr(input logic [2:0] op,
        input logic [BW-1:0] pv, input logic [63:0] din);
        if (op == 3'h1)
            return {din[31:0], ID_VAL};
        if (!op[0] && op != 3'h6)
            return {din[63-BW:0], pv};
        return {din[62:0], 1'b0};
    endfunction

    initial
    begin
        #100000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        logic [63:0] din;
        logic [63:0] dout;
        logic [2:0] op;
        logic die;
        logic q;
        #1;
        repeat (4) u_host.tick(1'b1, 1'b1, 1'b0, 1'b1, q);
        @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        cmp_vec(64'({tdo_oe, extest, hiz}), 64'h0);
        repeat (2) u_host.go_reset(1'b1);
        din = {$random(seed), $random(seed)};
        u_host.scan(1'b0, 64, din, 1'b1, '1, dout);
        cmp_vec(dout, exp_dr(3'h1, pins, din));
        for (int k = 0; k < 14; k++)
        begin
            op = (k < 8) ? 3'(k) : 3'($random(seed));
            die = (k < 8) ? (k != 7) : 1'($random(seed));
            din = {$random(seed), $random(seed)};
            @(posedge ref_clk);
            #1 pins = BW'($random(seed));
            u_host.go_reset(k[0]);
            u_host.scan(1'b1, 3, 64'(op), 1'b1, '1, dout);
            cmp_vec(dout, 64'h1);
            u_host.scan(1'b0, 64, din, die, '1, dout);
            if (!die)
                din = '1;
            cmp_vec(dout, exp_dr(op, pins, din));
            if (!op[0] && op != 3'h6)
                cmp_vec(64'(drive), 64'(din[63 -: BW]));
            cmp_vec(64'({extest, hiz}), 64'({op == 3'h0, op == 3'h4}));
        end
        // park in data shift, then freeze: mode-select high must not exit
        u_host.tick(1'b1, 1'b1, 1'b0, 1'b1, q);
        repeat (2) u_host.tick(1'b0, 1'b1, 1'b0, 1'b1, q);
        cmp_vec(64'(tdo_oe), 64'h1);
        @(posedge ref_clk);
        #1 clk_en = 1'b0;
        repeat (2) u_host.tick(1'b0, 1'b1, 1'b0, 1'b1, q);
        repeat (8) u_host.tick(1'b1, 1'b1, 1'b0, 1'b1, q);
        cmp_vec(64'(tdo_oe), 64'h1);
        end_sim();
    end
endmodule
